// >>> src/slc_pkg.sv
// package: register map, field layout and reset values of the lock/output config bank
package slc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_REF_FSK = 8'h22;
    localparam logic [7:0] IDX_REFERENCE_MULTIPLIER_OUT = 8'h23;
    localparam logic [7:0] IDX_LD_PIN = 8'h27;
    localparam logic [7:0] IDX_STATUS = 8'h28;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h29;
    localparam logic [7:0] IDX_IRQ_EN = 8'h2A;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h2B;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;

    localparam logic [15:0] RST_REF_FSK = 16'h1000;
    localparam logic [15:0] RST_REFERENCE_MULTIPLIER_OUT = 16'h0647;
    localparam logic [15:0] RST_LD_PIN = 16'h11F0;

    // lock detect / pin config field positions
    localparam int LOCK_DETECT_ENABLE_BIT = 0;
    localparam int MUX_SEL_BIT = 3;
    // reference control field position
    localparam int TERM_BIT = 15;
    localparam int SETTLE_W = 11;
    localparam logic [SETTLE_W-1:0] SETTLE_MIN = 11'h001;

    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_SETTLE_DONE = 2;

    // multiplier wait and output control layout
    typedef struct packed {
        logic [1:0] reserved;
        logic [SETTLE_W-1:0] multiplier_settle_count;
        logic output_mute_until_lock;
        logic tx_output_drive_type;
        logic rx_output_drive_type;
    } slc_reference_multiplier_out_s;

    // status word read back by software
    typedef struct packed {
        logic settle_busy;
        logic outputs_muted;
        logic lock_detect;
        logic pll_locked;
    } slc_status_s;

    typedef enum logic [1:0] {
        SLC_IDLE = 2'b01,
        SLC_SETTLE = 2'b10
    } slc_state_e;
endpackage : slc_pkg

// >>> src/slc_regs.sv
// lock detect, multiplier settle and output buffer configuration bank behind apb
//
// Contract
// - pin carries readback data or lock detect
// - lock detect runs only while enabled
// - settle field counts reference cycles, 1 to 2047
// - settle wait in every switch, reset C8h
// - mute buffers until lock after listed events
// - lock loss after unmute keeps outputs active
// - tx output open drain or push-pull
// - rx output open drain or push-pull
// - reference input 50 ohm termination enable
module slc_regs (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic pll_lock_raw_in,
    input wire logic readback_sdo_in,
    input wire logic manual_vco_change_in,
    input wire logic profile_swap_in,
    output logic multiplexed_status_pin_out,
    output logic settle_busy_out,
    output logic outputs_muted_out,
    output logic tx_push_pull_out,
    output logic rx_push_pull_out,
    output logic termination_enable_out,
    output logic irq_out
);
    // ***************************************************
    // apb slave
    // ***************************************************
    logic [15:0] ref_fsk;
    logic [15:0] reference_multiplier_out_raw;
    logic [15:0] ld_pin;
    logic [slc_pkg::IRQ_W-1:0] irq_stat;
    logic [slc_pkg::IRQ_W-1:0] irq_en;
    slc_pkg::slc_reference_multiplier_out_s reference_multiplier_out;
    slc_pkg::slc_status_s status;
    logic [slc_pkg::IDX_W-1:0] idx;
    logic access;
    logic commit;
    logic wr;
    logic mapped;
    logic [31:0] next_rdata;

    assign reference_multiplier_out = slc_pkg::slc_reference_multiplier_out_s'(reference_multiplier_out_raw);
    assign idx = paddr_in[slc_pkg::ADDR_LSB +: slc_pkg::IDX_W];
    assign access = psel_in & penable_in;
    // pready is a flop, so the write lands on the edge that samples it high
    assign commit = access & pready_out;
    assign wr = commit & pwrite_in & mapped;

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h0000_0000;
        case (idx)
            slc_pkg::IDX_REF_FSK: next_rdata = {16'h0000, ref_fsk};
            slc_pkg::IDX_REFERENCE_MULTIPLIER_OUT: next_rdata = {16'h0000, reference_multiplier_out_raw};
            slc_pkg::IDX_LD_PIN: next_rdata = {16'h0000, ld_pin};
            slc_pkg::IDX_STATUS: next_rdata = {28'h000_0000, status};
            slc_pkg::IDX_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
            slc_pkg::IDX_IRQ_EN: next_rdata = {29'h0000_0000, irq_en};
            slc_pkg::IDX_IRQ_CLR: next_rdata = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
    end

    // one wait state on every access
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= access & ~pready_out;
            prdata_out <= (access & ~pready_out & ~pwrite_in) ? next_rdata : 32'h0000_0000;
            pslverr_out <= access & ~pready_out & ~mapped;
        end
    end

    // ***************************************************
    // configuration registers
    // ***************************************************
    // reserved fields are stored as written; software owns their values
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ref_fsk <= slc_pkg::RST_REF_FSK;
            reference_multiplier_out_raw <= slc_pkg::RST_REFERENCE_MULTIPLIER_OUT;
            ld_pin <= slc_pkg::RST_LD_PIN;
        end else if (wr) begin
            if (idx == slc_pkg::IDX_REF_FSK) begin
                ref_fsk <= pwdata_in[15:0];
            end
            if (idx == slc_pkg::IDX_REFERENCE_MULTIPLIER_OUT) begin
                reference_multiplier_out_raw <= pwdata_in[15:0];
            end
            if (idx == slc_pkg::IDX_LD_PIN) begin
                ld_pin <= pwdata_in[15:0];
            end
        end
    end

    // ***************************************************
    // lock input synchroniser
    // ***************************************************
    logic [2:0] lock_ff;
    logic pll_locked;
    logic lock_detect;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            lock_ff <= 3'h0;
            pll_locked <= 1'b0;
        end else begin
            lock_ff <= {lock_ff[1:0], pll_lock_raw_in};
            if (lock_ff[1] == lock_ff[2]) begin
                pll_locked <= lock_ff[2];
            end
        end
    end

    assign lock_detect = ld_pin[slc_pkg::LOCK_DETECT_ENABLE_BIT] & pll_locked;

    // ***************************************************
    // multiplier settle wait
    // ***************************************************
    // clock_in is the reference oscillator clock, so one count is one cycle
    slc_pkg::slc_state_e state;
    logic [slc_pkg::SETTLE_W-1:0] settle_cnt;
    logic freq_switch;
    logic settle_done;

    assign freq_switch = manual_vco_change_in | profile_swap_in;
    assign settle_done = (state == slc_pkg::SLC_SETTLE) && (settle_cnt == slc_pkg::SETTLE_MIN);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state <= slc_pkg::SLC_IDLE;
            settle_cnt <= slc_pkg::SETTLE_MIN;
        end else if (freq_switch) begin
            // a new switch restarts the wait; a zero count is taken as one cycle
            state <= slc_pkg::SLC_SETTLE;
            settle_cnt <= (reference_multiplier_out.multiplier_settle_count == '0) ? slc_pkg::SETTLE_MIN
                : reference_multiplier_out.multiplier_settle_count;
        end else begin
            case (state)
                slc_pkg::SLC_SETTLE: begin
                    if (settle_cnt == slc_pkg::SETTLE_MIN) begin
                        state <= slc_pkg::SLC_IDLE;
                    end else begin
                        settle_cnt <= settle_cnt - slc_pkg::SETTLE_MIN;
                    end
                end
                default: state <= slc_pkg::SLC_IDLE;
            endcase
        end
    end

    // ***************************************************
    // output mute until lock
    // ***************************************************
    logic mute_pending;

    // init counts as a muting event: the flop leaves reset set
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            mute_pending <= 1'b1;
        end else if (freq_switch) begin
            mute_pending <= 1'b1;
        end else if (state == slc_pkg::SLC_IDLE && pll_locked) begin
            mute_pending <= 1'b0;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign status = '{settle_busy: state == slc_pkg::SLC_SETTLE,
        outputs_muted: mute_pending & reference_multiplier_out.output_mute_until_lock,
        lock_detect: lock_detect, pll_locked: pll_locked};

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            multiplexed_status_pin_out <= 1'b0;
            settle_busy_out <= 1'b0;
            outputs_muted_out <= 1'b1;
            tx_push_pull_out <= 1'b1;
            rx_push_pull_out <= 1'b1;
            termination_enable_out <= 1'b0;
        end else begin
            multiplexed_status_pin_out <= ld_pin[slc_pkg::MUX_SEL_BIT] ? lock_detect
                : readback_sdo_in;
            settle_busy_out <= status.settle_busy;
            // lock loss alone never re-mutes: only a listed event sets the flag
            outputs_muted_out <= status.outputs_muted;
            tx_push_pull_out <= reference_multiplier_out.tx_output_drive_type;
            rx_push_pull_out <= reference_multiplier_out.rx_output_drive_type;
            termination_enable_out <= ref_fsk[slc_pkg::TERM_BIT];
        end
    end

    // ***************************************************
    // interrupts
    // ***************************************************
    logic lock_detect_q;
    logic [slc_pkg::IRQ_W-1:0] irq_event;
    logic [slc_pkg::IRQ_W-1:0] irq_clear;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            lock_detect_q <= 1'b0;
        end else begin
            lock_detect_q <= lock_detect;
        end
    end

    assign irq_clear = (wr && idx == slc_pkg::IDX_IRQ_CLR) ? pwdata_in[slc_pkg::IRQ_W-1:0]
        : '0;

    genvar gi;
    generate
        for (gi = 0; gi < slc_pkg::IRQ_W; gi++) begin : g_irq
            // a new event in the clearing cycle wins over the clear
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    irq_stat[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_stat[gi] <= 1'b1;
                end else if (irq_clear[gi]) begin
                    irq_stat[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        irq_event = '0;
        irq_event[slc_pkg::IRQ_LOCK_GAIN] = lock_detect & ~lock_detect_q;
        irq_event[slc_pkg::IRQ_LOCK_LOSS] = ~lock_detect & lock_detect_q;
        irq_event[slc_pkg::IRQ_SETTLE_DONE] = settle_done & ~freq_switch;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_en <= '0;
            irq_out <= 1'b0;
        end else begin
            if (wr && idx == slc_pkg::IDX_IRQ_EN) begin
                irq_en <= pwdata_in[slc_pkg::IRQ_W-1:0];
            end
            irq_out <= |(irq_stat & irq_en);
        end
    end
endmodule : slc_regs

// >>> sim/slc_regs_checker.sv
// checker: port-level properties of the lock and output config bank
module slc_regs_checker (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic pll_lock_raw_in,
    input wire logic readback_sdo_in,
    input wire logic manual_vco_change_in,
    input wire logic profile_swap_in,
    input wire logic multiplexed_status_pin_out,
    input wire logic settle_busy_out,
    input wire logic outputs_muted_out,
    input wire logic tx_push_pull_out,
    input wire logic rx_push_pull_out,
    input wire logic termination_enable_out,
    input wire logic irq_out
);
    timeunit 1ns / 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    logic [15:0] reference_multiplier;
    logic [3:0] ld;
    logic [10:0] run;
    logic sw, wr;
    assign sw = manual_vco_change_in || profile_swap_in;
    assign wr = psel_in && penable_in && pwrite_in && pready_out;
    // ****************
    // register shadows
    // ****************
    // writes landing while a wait runs are not modelled
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reference_multiplier <= slc_pkg::RST_REFERENCE_MULTIPLIER_OUT;
            ld <= 4'h0;
        end else if (wr && paddr_in == 32'h8C) begin
            reference_multiplier <= pwdata_in[15:0];
        end else if (wr && paddr_in == 32'h9C) begin
            ld <= pwdata_in[3:0];
        end
    end
    always_ff @(posedge clock_in) begin
        run <= (srst_in || sw || !settle_busy_out) ? 11'h000 : run + 11'h001;
    end
    property p_mux; !$past(srst_in) && !$past(ld[3]) |->
        multiplexed_status_pin_out == $past(readback_sdo_in); endproperty
    a_mux: assert property (p_mux) else $error("pin not readback");
    property p_ld_off; $past(ld[3]) && !$past(ld[0]) && !$past(ld[0], 2) |->
        !multiplexed_status_pin_out; endproperty
    a_ld_off: assert property (p_ld_off) else $error("lock shown while off");
    property p_len; $fell(settle_busy_out) |-> run == reference_multiplier[13:3]; endproperty
    a_len: assert property (p_len) else $error("settle length");
    // state loads on the pulse edge, the busy flop follows one edge later
    property p_start; sw |-> ##2 settle_busy_out; endproperty
    a_start: assert property (p_start) else $error("no settle wait");
    property p_hold; settle_busy_out && outputs_muted_out && !psel_in |=> outputs_muted_out;
    endproperty
    a_hold: assert property (p_hold) else $error("unmuted during wait");
    // a switch re-mutes two edges on, so the cycle after a pulse is exempt
    property p_keep; !outputs_muted_out && !sw && !$past(sw) |=> !outputs_muted_out;
    endproperty
    a_keep: assert property (p_keep) else $error("muted again");
    property p_tx; wr && paddr_in == 32'h8C |-> ##2 tx_push_pull_out == $past(pwdata_in[1], 2);
    endproperty
    a_tx: assert property (p_tx) else $error("tx drive type");
    property p_rx; wr && paddr_in == 32'h8C |-> ##2 rx_push_pull_out == $past(pwdata_in[0], 2);
    endproperty
    a_rx: assert property (p_rx) else $error("rx drive type");
    property p_term; wr && paddr_in == 32'h88 |-> ##2
        termination_enable_out == $past(pwdata_in[15], 2); endproperty
    a_term: assert property (p_term) else $error("termination");
    c_settle: cover property ($fell(settle_busy_out));
    c_unmute: cover property ($fell(outputs_muted_out));
    c_irq: cover property ($rose(irq_out));
endmodule : slc_regs_checker
bind slc_regs slc_regs_checker slc_regs_checker_inst (.clock_in, .srst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .pll_lock_raw_in, .readback_sdo_in, .manual_vco_change_in, .profile_swap_in, .irq_out,
    .multiplexed_status_pin_out, .settle_busy_out, .outputs_muted_out, .tx_push_pull_out,
    .rx_push_pull_out, .termination_enable_out);

// >>> sim/slc_regs_bench.sv
// bench: apb driven checks of the lock and output config bank
module slc_regs_bench;
    timeunit 1ns / 1ps;
    logic clock_in, srst_in, psel_in, penable_in, pwrite_in, pll_lock_raw_in, readback_sdo_in;
    logic manual_vco_change_in, profile_swap_in, pready_out, pslverr_out, err, irq_out;
    logic multiplexed_status_pin_out, settle_busy_out, outputs_muted_out, tx_push_pull_out;
    logic rx_push_pull_out, termination_enable_out;
    logic [31:0] paddr_in, pwdata_in, prdata_out, rd;
    int num_errors = 0, checks = 0, n;
    wire [3:0] outs = {outputs_muted_out, tx_push_pull_out, rx_push_pull_out,
        termination_enable_out};
    slc_regs slc_regs_inst (.clock_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pll_lock_raw_in, .readback_sdo_in,
        .manual_vco_change_in, .profile_swap_in, .multiplexed_status_pin_out, .settle_busy_out,
        .outputs_muted_out, .tx_push_pull_out, .rx_push_pull_out, .termination_enable_out,
        .irq_out);
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // slave latency is not assumed: the wait ends on pready or the timeout
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_in);
        {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        {err, rd} = {pslverr_out, prdata_out};
        {psel_in, penable_in} <= 2'b00;
    endtask : apb
    task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rdchk
    task automatic results;
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    initial forever #5 clock_in = ~clock_in;
    initial begin
        // two full 2000-cycle settle waits plus register traffic
        repeat (6000) @(posedge clock_in);
        num_errors++;
        results();
    end
    initial begin
        {clock_in, srst_in, psel_in, penable_in, pwrite_in, pll_lock_raw_in} = 6'h10;
        {readback_sdo_in, manual_vco_change_in, profile_swap_in, paddr_in, pwdata_in} = 67'h0;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        rdchk("ref", 32'h88, 32'h1000);
        rdchk("reference_multiplier", 32'h8C, 32'h0647);
        rdchk("ldpin", 32'h9C, 32'h11F0);
        chk("outs", 32'hE, outs);
        // settle count 2000: 20 us of the 100 MHz reference clock
        apb(1'b1, 32'h8C, 32'h3E85);
        apb(1'b1, 32'h88, 32'h9000);
        apb(1'b1, 32'hA8, 32'h0004);
        chk("outs", 32'hB, outs);
        manual_vco_change_in <= 1'b1;
        @(posedge clock_in);
        manual_vco_change_in <= 1'b0;
        n = 0;
        repeat (2010) begin
            @(posedge clock_in);
            n += int'(settle_busy_out === 1'b1);
        end
        chk("settle", 32'h7D0, n);
        chk("irq", 32'h1, irq_out);
        rdchk("irq_stat", 32'hA4, 32'h4);
        chk("outs", 32'hB, outs);
        pll_lock_raw_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        chk("outs", 32'h3, outs);
        {pll_lock_raw_in, readback_sdo_in} <= 2'b01;
        apb(1'b1, 32'hAC, 32'h0004);
        apb(1'b1, 32'h9C, 32'h11F2);
        chk("outs_irq_pin", 32'hD, {outs, irq_out, multiplexed_status_pin_out});
        profile_swap_in <= 1'b1;
        @(posedge clock_in);
        {profile_swap_in, pll_lock_raw_in} <= 2'b01;
        // lock detect is enabled before the pin is switched over to it
        apb(1'b1, 32'h9C, 32'h11F3);
        chk("outs", 32'hB, outs);
        repeat (2010) @(posedge clock_in);
        chk("outs_pin", 32'h7, {outs, multiplexed_status_pin_out});
        apb(1'b1, 32'h9C, 32'h11FB);
        repeat (6) @(posedge clock_in);
        chk("pin", 32'h1, multiplexed_status_pin_out);
        apb(1'b1, 32'h9C, 32'h11FA);
        repeat (6) @(posedge clock_in);
        chk("pin", 32'h0, multiplexed_status_pin_out);
        rdchk("unmapped", 32'h100, 32'h0);
        chk("err", 32'h1, err);
        results();
    end
endmodule : slc_regs_bench
